// [hdl/vfs_byte_store.sv]
/*
  vfs_byte_store: byte storage in flip-flops with one write port and two
  combinational read ports, indexed by address.
  assumes: callers register the read data before it reaches a pin.
*/
`timescale 1ns/1ps
module vfs_byte_store #(
  parameter int DEPTH = 512,
  parameter int AW    = 9
) (
  input  wire logic          core_clk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [7:0]    wr_data,
  input  wire logic [AW-1:0] rd_addr_a,
  output      logic [7:0]    rd_data_a,
  input  wire logic [AW-1:0] rd_addr_b,
  output      logic [7:0]    rd_data_b
);
  logic [7:0] mem_reg [DEPTH];

  // contents hold no reset value; the write port loads them
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem_reg[wr_addr] <= wr_data;
    end
  end

  // read ports
  assign rd_data_a = mem_reg[rd_addr_a];
  assign rd_data_b = mem_reg[rd_addr_b];
endmodule

// [hdl/vfs_top.sv]
/*
  vfs_top: sliced-data queue, slicer status, interrupt conditions, switch
  pixel timing, full-field line mode selection and configuration memory.
  assumes: register port strobes and slicer signals are on core_clk.
*/
`timescale 1ns/1ps
module vfs_top
  import vfs_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output      logic [7:0] reg_rdata,
  input  wire logic       line_start,
  input  wire logic [9:0] line_bytes,
  input  wire logic       byte_valid,
  input  wire logic [7:0] byte_data,
  input  wire logic [5:0] service_done,
  input  wire logic       line_strobe,
  input  wire logic [9:0] line_num,
  input  wire logic       field_two,
  input  wire logic       sync_fall,
  input  wire logic [8:0] cfg_slicer_addr,
  output      logic [7:0] cfg_slicer_data,
  output      logic [7:0] slice_mode,
  output      logic       slice_enable,
  output      logic       settings_load,
  output      logic       anc_valid,
  output      logic [7:0] anc_data,
  input  wire logic       anc_ready,
  output      logic       read_regs_clear,
  output      logic       irq_active
);
  // register state
  logic [7:0]              threshold_reg;
  logic [7:0]              line_int_reg;
  logic [7:0]              switch_l_reg;
  logic [1:0]              switch_h_reg;
  logic                    route_host_reg;
  logic                    ff_enable_reg;
  logic [7:0]              ff_mode_reg;
  logic [7:0]              line_mode_reg [VFS_LM_COUNT];
  logic [1:0]              int_status_reg;
  logic [1:0]              int_enable_reg;
  logic                    full_err_reg;
  logic [5:0]              avail_reg;
  logic [VFS_CFG_AW-1:0]   cfg_addr_reg;
  // queue, line admission, threshold and pixel counter state
  logic [VFS_QUEUE_AW-1:0] wr_ptr_reg;
  logic [VFS_QUEUE_AW-1:0] rd_ptr_reg;
  logic [VFS_QUEUE_AW:0]   byte_cnt_reg;
  logic [VFS_QUEUE_AW:0]   byte_cnt_next;
  logic                    line_take_reg;
  logic [9:0]              line_left_reg;
  logic                    above_reg;
  logic [9:0]              pix_cnt_reg;

  // register port decode
  wire sel_data    = reg_addr == VFS_ADDR_QUEUE_DATA;
  wire sel_cfg     = reg_addr == VFS_ADDR_CFG_DATA;
  wire wr_flush    = reg_wr && reg_addr == VFS_ADDR_FLUSH;
  wire wr_status   = reg_wr && reg_addr == VFS_ADDR_STATUS;
  wire wr_intst    = reg_wr && reg_addr == VFS_ADDR_INT_STATUS;
  wire wr_cfg      = reg_wr && sel_cfg;
  wire rd_cfg      = reg_rd && sel_cfg;
  wire in_lm_range = reg_addr >= VFS_ADDR_LINE_MODE0 && reg_addr <= VFS_ADDR_LINE_MODEN;
  wire [5:0] lm_wr_idx = 6'(reg_addr - VFS_ADDR_LINE_MODE0);

  // queue occupancy and word count
  wire        queue_empty = byte_cnt_reg == '0;
  wire [9:0]  queue_free  = 10'(VFS_QUEUE_BYTES) - byte_cnt_reg;
  wire [7:0]  word_count  = byte_cnt_reg[9:1] > 9'h0FF ? 8'hFF : byte_cnt_reg[8:1];
  wire [7:0]  queue_head;
  wire [7:0]  cfg_host_data;
  wire [7:0]  cfg_slicer_data_w;

  // line acceptance: whole line must fit, checked against free space
  wire line_fits  = line_bytes <= queue_free;
  wire line_drop  = line_start && !line_fits;
  wire push       = line_take_reg && byte_valid && line_left_reg != '0 && byte_cnt_reg != 10'(VFS_QUEUE_BYTES);

  // queue draining, by host read or ancillary send
  wire host_pop   = route_host_reg && reg_rd && sel_data && !queue_empty;
  wire anc_load   = !route_host_reg && !queue_empty && (!anc_valid || anc_ready);
  wire pop        = host_pop || anc_load;

  // threshold and line conditions
  wire above_now  = word_count > threshold_reg;
  wire thr_event  = above_now && !above_reg;
  wire line_field = field_two ? line_int_reg[VFS_LI_F2_EN] : line_int_reg[VFS_LI_F1_EN];
  wire line_event = line_strobe && line_field && line_num == {4'h0, line_int_reg[5:0]}
                    && line_int_reg[5:0] >= VFS_LINE_MIN;

  // per-line mode selection for the next line
  wire       lm_line   = line_num >= VFS_LM_FIRST_LINE && line_num <= VFS_LM_LAST_LINE;
  wire [9:0] lm_offset = line_num - VFS_LM_FIRST_LINE;
  wire [5:0] lm_idx    = {lm_offset[4:0], field_two};
  wire [7:0] lm_entry  = lm_line ? line_mode_reg[lm_idx] : VFS_MODE_FF;
  wire [7:0] mode_pick = (lm_entry == VFS_MODE_FF && ff_enable_reg) ? ff_mode_reg : lm_entry;
  wire [9:0] switch_pos = {switch_h_reg, switch_l_reg};
  wire       switch_hit = pix_cnt_reg == switch_pos;

  // read data selection
  function automatic logic [7:0] lm_read(input logic [7:0] addr, input logic [7:0] entry);
    lm_read = (addr >= VFS_ADDR_LINE_MODE0 && addr <= VFS_ADDR_LINE_MODEN) ? entry : 8'h00;
  endfunction

  wire [7:0] status_val = {full_err_reg, queue_empty, avail_reg};
  wire [7:0] lm_rd_entry = line_mode_reg[lm_wr_idx < 6'(VFS_LM_COUNT) ? lm_wr_idx : 6'h00];
  logic [7:0] rd_mux;
  always_comb begin
    unique case (reg_addr)
      VFS_ADDR_QUEUE_DATA: rd_mux = (route_host_reg && !queue_empty) ? queue_head : 8'h00;
      VFS_ADDR_INT_STATUS: rd_mux = {5'h00, int_status_reg, 1'b0};
      VFS_ADDR_INT_ENABLE: rd_mux = {5'h00, int_enable_reg, 1'b0};
      VFS_ADDR_CFG_DATA:   rd_mux = cfg_host_data;
      VFS_ADDR_CFG_ADDR_L: rd_mux = cfg_addr_reg[7:0];
      VFS_ADDR_CFG_ADDR_H: rd_mux = {7'h00, cfg_addr_reg[8]};
      VFS_ADDR_STATUS:     rd_mux = status_val;
      VFS_ADDR_WORD_COUNT: rd_mux = word_count;
      VFS_ADDR_THRESHOLD:  rd_mux = threshold_reg;
      VFS_ADDR_LINE_INT:   rd_mux = line_int_reg;
      VFS_ADDR_SWITCH_L:   rd_mux = switch_l_reg;
      VFS_ADDR_SWITCH_H:   rd_mux = {6'h00, switch_h_reg};
      VFS_ADDR_ROUTE:      rd_mux = {7'h00, route_host_reg};
      VFS_ADDR_FF_ENABLE:  rd_mux = {7'h00, ff_enable_reg};
      VFS_ADDR_FF_MODE:    rd_mux = ff_mode_reg;
      default:             rd_mux = lm_read(reg_addr, lm_rd_entry);
    endcase
  end

  // queue byte storage
  vfs_byte_store #(
    .DEPTH(VFS_QUEUE_BYTES),
    .AW   (VFS_QUEUE_AW)
  ) u_queue_store (
    .core_clk (core_clk),
    .wr_en    (push),
    .wr_addr  (wr_ptr_reg),
    .wr_data  (byte_data),
    .rd_addr_a(rd_ptr_reg),
    .rd_data_a(queue_head),
    .rd_addr_b(rd_ptr_reg),
    .rd_data_b()
  );

  // slicer configuration memory, 32 sets of 16 bytes
  vfs_byte_store #(
    .DEPTH(VFS_CFG_BYTES),
    .AW   (VFS_CFG_AW)
  ) u_cfg_store (
    .core_clk (core_clk),
    .wr_en    (wr_cfg),
    .wr_addr  (cfg_addr_reg),
    .wr_data  (reg_wdata),
    .rd_addr_a(cfg_addr_reg),
    .rd_data_a(cfg_host_data),
    .rd_addr_b(cfg_slicer_addr),
    .rd_data_b(cfg_slicer_data_w)
  );

  // byte count: flush wins, else push and pop together
  always_comb begin
    byte_cnt_next = byte_cnt_reg;
    if (push && !pop) begin
      byte_cnt_next = byte_cnt_reg + 10'h001;
    end else if (pop && !push) begin
      byte_cnt_next = byte_cnt_reg - 10'h001;
    end
  end

  // queue pointers and occupancy
  always_ff @(posedge core_clk) begin
    if (!rst_n || wr_flush) begin
      wr_ptr_reg   <= '0;
      rd_ptr_reg   <= '0;
      byte_cnt_reg <= '0;
    end else begin
      wr_ptr_reg   <= push ? wr_ptr_reg + 9'h001 : wr_ptr_reg;
      rd_ptr_reg   <= pop ? rd_ptr_reg + 9'h001 : rd_ptr_reg;
      byte_cnt_reg <= byte_cnt_next;
    end
  end

  // line admission: a dropped line writes nothing
  always_ff @(posedge core_clk) begin
    if (!rst_n || wr_flush) begin
      line_take_reg <= 1'b0;
      line_left_reg <= '0;
    end else if (line_start) begin
      line_take_reg <= line_fits;
      line_left_reg <= line_bytes;
    end else if (push) begin
      line_left_reg <= line_left_reg - 10'h001;
    end
  end

  // slicer status flags: set wins over write-one clear
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      full_err_reg <= 1'b0;
      avail_reg    <= '0;
    end else begin
      full_err_reg <= line_drop || (full_err_reg && !(wr_status && reg_wdata[VFS_ST_FULL_ERR]));
      avail_reg    <= service_done | (avail_reg & ~(wr_status ? reg_wdata[5:0] : 6'h00));
    end
  end

  // latched interrupt conditions
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      above_reg      <= 1'b0;
      int_status_reg <= '0;
    end else begin
      above_reg         <= above_now;
      int_status_reg[1] <= thr_event || (int_status_reg[1] && !(wr_intst && reg_wdata[VFS_INT_THRESH]));
      int_status_reg[0] <= line_event || (int_status_reg[0] && !(wr_intst && reg_wdata[VFS_INT_LINE]));
    end
  end

  // software-written control registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      threshold_reg  <= VFS_RST_THRESHOLD;
      line_int_reg   <= VFS_RST_LINE_INT;
      switch_l_reg   <= VFS_RST_SWITCH_L;
      switch_h_reg   <= VFS_RST_SWITCH_H;
      route_host_reg <= VFS_RST_ROUTE;
      ff_enable_reg  <= 1'b0;
      ff_mode_reg    <= VFS_RST_FF_MODE;
      int_enable_reg <= '0;
    end else if (reg_wr) begin
      unique case (reg_addr)
        VFS_ADDR_THRESHOLD:  threshold_reg  <= reg_wdata;
        VFS_ADDR_LINE_INT:   line_int_reg   <= reg_wdata;
        VFS_ADDR_SWITCH_L:   switch_l_reg   <= reg_wdata;
        VFS_ADDR_SWITCH_H:   switch_h_reg   <= reg_wdata[1:0];
        VFS_ADDR_ROUTE:      route_host_reg <= reg_wdata[0];
        VFS_ADDR_FF_ENABLE:  ff_enable_reg  <= reg_wdata[0];
        VFS_ADDR_FF_MODE:    ff_mode_reg    <= reg_wdata;
        VFS_ADDR_INT_ENABLE: int_enable_reg <= reg_wdata[2:1];
        default:             int_enable_reg <= int_enable_reg;
      endcase
    end
  end

  // line mode entries, all reset to slicer off
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < VFS_LM_COUNT; i++) begin
        line_mode_reg[i] <= VFS_RST_LINE_MODE;
      end
    end else if (reg_wr && in_lm_range) begin
      line_mode_reg[lm_wr_idx] <= reg_wdata;
    end
  end

  // configuration address counter: preload, then step on each data access
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cfg_addr_reg <= '0;
    end else if (reg_wr && reg_addr == VFS_ADDR_CFG_ADDR_L) begin
      cfg_addr_reg[7:0] <= reg_wdata;
    end else if (reg_wr && reg_addr == VFS_ADDR_CFG_ADDR_H) begin
      cfg_addr_reg[8] <= reg_wdata[0];
    end else if (wr_cfg || rd_cfg) begin
      cfg_addr_reg <= cfg_addr_reg + 9'h001;
    end
  end

  // pixel position from the sync edge and settings load pulse
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pix_cnt_reg   <= VFS_PIX_MAX;
      settings_load <= 1'b0;
    end else begin
      pix_cnt_reg   <= sync_fall ? '0 : (pix_cnt_reg == VFS_PIX_MAX ? pix_cnt_reg : pix_cnt_reg + 10'h001);
      settings_load <= switch_hit && !sync_fall && pix_cnt_reg != VFS_PIX_MAX;
    end
  end

  // next-line standard, loaded at the switch pixel
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      slice_mode   <= VFS_MODE_FF;
      slice_enable <= 1'b0;
    end else if (switch_hit && !sync_fall && pix_cnt_reg != VFS_PIX_MAX) begin
      slice_mode   <= mode_pick;
      slice_enable <= mode_pick[3:0] != VFS_MODE_OFF;
    end
  end

  // ancillary output stage on the video port
  always_ff @(posedge core_clk) begin
    if (!rst_n || wr_flush) begin
      anc_valid <= 1'b0;
      anc_data  <= '0;
    end else if (anc_load) begin
      anc_valid <= 1'b1;
      anc_data  <= queue_head;
    end else if (anc_ready) begin
      anc_valid <= 1'b0;
    end
  end

  // register read data, pin outputs
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata       <= '0;
      read_regs_clear <= 1'b0;
      irq_active      <= 1'b0;
      cfg_slicer_data <= '0;
    end else begin
      reg_rdata       <= reg_rd ? rd_mux : reg_rdata;
      read_regs_clear <= wr_flush;
      irq_active      <= |(int_status_reg & int_enable_reg);
      cfg_slicer_data <= cfg_slicer_data_w;
    end
  end
endmodule

// [pkg/vfs_pkg.sv]
/*
  vfs_pkg: register offsets, field positions, reset values and sizes for the
  sliced-data queue and slicer control block.
  assumes: an 8-bit register port decoded by the control-bus logic upstream.
*/
package vfs_pkg;
  // register offsets
  localparam logic [7:0] VFS_ADDR_QUEUE_DATA = 8'hB0;
  localparam logic [7:0] VFS_ADDR_INT_STATUS = 8'hC0;
  localparam logic [7:0] VFS_ADDR_INT_ENABLE = 8'hC1;
  localparam logic [7:0] VFS_ADDR_CFG_DATA   = 8'hC3;
  localparam logic [7:0] VFS_ADDR_CFG_ADDR_L = 8'hC4;
  localparam logic [7:0] VFS_ADDR_CFG_ADDR_H = 8'hC5;
  localparam logic [7:0] VFS_ADDR_STATUS     = 8'hC6;
  localparam logic [7:0] VFS_ADDR_WORD_COUNT = 8'hC7;
  localparam logic [7:0] VFS_ADDR_THRESHOLD  = 8'hC8;
  localparam logic [7:0] VFS_ADDR_FLUSH      = 8'hC9;
  localparam logic [7:0] VFS_ADDR_LINE_INT   = 8'hCA;
  localparam logic [7:0] VFS_ADDR_SWITCH_L   = 8'hCB;
  localparam logic [7:0] VFS_ADDR_SWITCH_H   = 8'hCC;
  localparam logic [7:0] VFS_ADDR_ROUTE      = 8'hCD;
  localparam logic [7:0] VFS_ADDR_FF_ENABLE  = 8'hCF;
  localparam logic [7:0] VFS_ADDR_LINE_MODE0 = 8'hD0;
  localparam logic [7:0] VFS_ADDR_LINE_MODEN = 8'hFB;
  localparam logic [7:0] VFS_ADDR_FF_MODE    = 8'hFC;
  // reset values
  localparam logic [7:0] VFS_RST_THRESHOLD   = 8'h80;
  localparam logic [7:0] VFS_RST_LINE_INT    = 8'h00;
  localparam logic [7:0] VFS_RST_SWITCH_L    = 8'h4E;
  localparam logic [1:0] VFS_RST_SWITCH_H    = 2'h0;
  localparam logic       VFS_RST_ROUTE       = 1'b1;
  localparam logic [7:0] VFS_RST_LINE_MODE   = 8'hFF;
  localparam logic [7:0] VFS_RST_FF_MODE     = 8'h7F;
  // field positions
  localparam int VFS_ST_FULL_ERR  = 7;
  localparam int VFS_ST_EMPTY     = 6;
  localparam int VFS_INT_THRESH   = 2;
  localparam int VFS_INT_LINE     = 1;
  localparam int VFS_LI_F1_EN     = 7;
  localparam int VFS_LI_F2_EN     = 6;
  localparam logic [3:0] VFS_MODE_OFF = 4'hF;
  localparam logic [7:0] VFS_MODE_FF  = 8'hFF;
  localparam logic [5:0] VFS_LINE_MIN = 6'h02;
  // sizes
  localparam int VFS_QUEUE_BYTES = 512;
  localparam int VFS_QUEUE_AW    = 9;
  localparam int VFS_CFG_BYTES   = 512;
  localparam int VFS_CFG_AW      = 9;
  localparam int VFS_LM_COUNT    = 44;
  localparam logic [9:0] VFS_LM_FIRST_LINE = 10'h006;
  localparam logic [9:0] VFS_LM_LAST_LINE  = 10'h01B;
  localparam logic [9:0] VFS_PIX_MAX       = 10'h3FF;
endpackage

// [test/testbench.sv]
/*
  testbench: register-port tests of vfs_top with a slicer model.
  assumes: register strobes are one-cycle pulses, reads answer next cycle.
*/
`timescale 1ns/1ps
module testbench;
  import vfs_pkg::*;
  logic       core_clk, rst_n, reg_wr, reg_rd, line_strobe, field_two, sync_fall, anc_ready, go;
  logic       line_start, byte_valid, busy, slice_enable, settings_load, anc_valid, read_regs_clear, irq_active;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, anc_data, slice_mode, base, byte_data, slc_data;
  logic [8:0] slc_addr;
  logic [9:0] line_num, nb, line_bytes;
  logic [5:0] service_done;
  int         n_mismatch, checked, i, n;
  logic [15:0] rst_tab [10] = '{16'hC640, 16'hC700, 16'hC880, 16'hCA00, 16'hCB4E,
                                16'hCC00, 16'hCD01, 16'hCF00, 16'hCE00, 16'hFC7F};
  logic [15:0] li_tab [6] = '{16'h8515, 16'h8516, 16'h4517, 16'hC104, 16'hC000, 16'hC518};
  logic [31:0] sm_tab [4] = '{32'h0701_0607, 32'hFF01_063C, 32'hFF01_643C, 32'hFF00_64FF};

  vfs_top dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .line_start(line_start),
    .line_bytes(line_bytes), .byte_valid(byte_valid), .byte_data(byte_data), .service_done(service_done),
    .line_strobe(line_strobe), .line_num(line_num), .field_two(field_two), .sync_fall(sync_fall),
    .cfg_slicer_addr(slc_addr), .cfg_slicer_data(slc_data), .slice_mode(slice_mode), .slice_enable(slice_enable),
    .settings_load(settings_load), .anc_valid(anc_valid), .anc_data(anc_data), .anc_ready(anc_ready),
    .read_regs_clear(read_regs_clear), .irq_active(irq_active));
  vfs_slicer_model u_src (.core_clk(core_clk), .rst_n(rst_n), .go(go), .nb(nb), .base(base),
    .line_start(line_start), .line_bytes(line_bytes), .byte_valid(byte_valid), .byte_data(byte_data),
    .busy(busy));

  // 25 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  // one slicer line, then wait for the model to finish under a bound
  task automatic send(input logic [9:0] count, input logic [7:0] b);
    int k;
    @(posedge core_clk);
    go   <= 1'b1;
    nb   <= count;
    base <= b;
    @(posedge core_clk);
    go <= 1'b0;
    #1;
    for (k = 0; k < 1100 && busy; k++) @(posedge core_clk);
    repeat (3) @(posedge core_clk);
  endtask

  // line start, then sync edge, then time for the switch pixel
  task automatic line_go(input logic [9:0] ln, input logic f2);
    @(posedge core_clk);
    line_strobe <= 1'b1;
    line_num    <= ln;
    field_two   <= f2;
    @(posedge core_clk);
    line_strobe <= 1'b0;
    sync_fall   <= 1'b1;
    @(posedge core_clk);
    sync_fall <= 1'b0;
    repeat (24) @(posedge core_clk);
    #1;
  endtask

  task automatic finish_test;
    $display("mismatches=%0d checks=%0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // hang guard, well beyond the expected run length
  initial begin
    repeat (30000) @(posedge core_clk);
    n_mismatch++;
    finish_test;
  end

  initial begin
    {rst_n, reg_wr, reg_rd, line_strobe, field_two, sync_fall, anc_ready, go} = 8'h00;
    {reg_addr, reg_wdata, base, nb, line_num, service_done, slc_addr} = '0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    for (n = 0; n < 10; n++) rchk(rst_tab[n][15:8], rst_tab[n][7:0]);
    // queue order, word count and sticky service flags
    send(10'h004, 8'hA0);
    rchk(8'hC7, 8'h02);
    rchk(8'hC6, 8'h00);
    rchk(8'hB0, 8'hA0);
    rchk(8'hB0, 8'hA1);
    rchk(8'hC7, 8'h01);
    for (n = 0; n < 6; n++) begin
      @(posedge core_clk);
      service_done <= 6'h01 << n;
      @(posedge core_clk);
      service_done <= 6'h00;
      wr(8'hB1, 8'h00);
      rchk(8'hB0, (n == 0) ? 8'hA2 : (n == 1) ? 8'hA3 : 8'h00);
      rchk(8'hC6, {1'b0, n >= 1, 6'h01 << n});
      wr(8'hC6, 8'(1 << n));
      rchk(8'hC6, (n >= 1) ? 8'h40 : 8'h00);
    end
    // flush
    send(10'h006, 8'h10);
    wr(8'hC9, 8'h5A);
    rchk(8'hC7, 8'h00);
    rchk(8'hC6, 8'h40);
    // overflow drops a whole line, a fitting line still goes in
    send(10'd500, 8'h00);
    rchk(8'hC7, 8'hFA);
    send(10'd20, 8'h00);
    rchk(8'hC6, 8'h80);
    rchk(8'hC7, 8'hFA);
    send(10'd10, 8'h00);
    rchk(8'hC7, 8'hFF);
    rchk(8'hC0, 8'h04);
    wr(8'hC1, 8'h04);
    repeat (2) @(posedge core_clk);
    #1;
    chk({7'h00, irq_active}, 8'h01);
    wr(8'hC0, 8'h04);
    rchk(8'hC0, 8'h00);
    wr(8'hC1, 8'h00);
    wr(8'hC6, 8'h80);
    wr(8'hC9, 8'h00);
    // line match with field enables and the forbidden lines
    for (n = 0; n < 6; n++) begin
      wr(8'hCA, li_tab[n][15:8]);
      line_go({4'h0, li_tab[n][7:2]}, li_tab[n][1]);
      rchk(8'hC0, li_tab[n][0] ? 8'h02 : 8'h00);
      wr(8'hC0, 8'h02);
    end
    // ancillary route with a stalled video port
    wr(8'hCD, 8'h00);
    send(10'h004, 8'hB0);
    chk({7'h00, anc_valid}, 8'h01);
    chk(anc_data, 8'hB0);
    rchk(8'hB0, 8'h00);
    @(posedge core_clk);
    anc_ready <= 1'b1;
    n = 0;
    for (i = 0; i < 40 && n < 4; i++) begin
      @(negedge core_clk);
      if (anc_valid === 1'b1) begin
        chk(anc_data, 8'hB0 + 8'(n));
        n++;
      end
    end
    @(posedge core_clk);
    anc_ready <= 1'b0;
    chk(8'(n), 8'h04);
    wr(8'hCD, 8'h01);
    rchk(8'hC6, 8'h40);
    // per-line standard against full-field standard
    wr(8'hCB, 8'h10);
    wr(8'hFC, 8'h3C);
    for (n = 0; n < 4; n++) begin
      wr(8'hD0, sm_tab[n][31:24]);
      wr(8'hCF, sm_tab[n][23:16]);
      line_go({2'h0, sm_tab[n][15:8]}, 1'b0);
      chk(slice_mode, sm_tab[n][7:0]);
      chk({7'h00, slice_enable}, {7'h00, sm_tab[n][3:0] != 4'hF});
    end
    // user configuration pair through the auto-incrementing port
    wr(8'hC4, 8'hC0);
    wr(8'hC5, 8'h01);
    for (n = 0; n < 4; n++) wr(8'hC3, 8'h5A + 8'(n));
    wr(8'hC4, 8'hC0);
    wr(8'hC5, 8'h01);
    for (n = 0; n < 4; n++) rchk(8'hC3, 8'h5A + 8'(n));
    // slicer side read of the same pair, registered one cycle later
    @(posedge core_clk);
    slc_addr <= 9'h1C2;
    repeat (2) @(posedge core_clk);
    #1;
    chk(slc_data, 8'h5C);
    finish_test;
  end
endmodule

bind vfs_top vfs_top_checker u_chk (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .sync_fall(sync_fall), .slice_mode(slice_mode),
  .slice_enable(slice_enable), .settings_load(settings_load), .anc_valid(anc_valid), .anc_data(anc_data),
  .anc_ready(anc_ready), .read_regs_clear(read_regs_clear), .irq_active(irq_active));

// [test/vfs_slicer_model.sv]
/*
  vfs_slicer_model: stands in for the slicing engine, sending one line of
  bytes per request; line_start first, then one byte per cycle.
  assumes: go is a one-cycle pulse from the bench, ignored while busy.
*/
`timescale 1ns/1ps
module vfs_slicer_model (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       go,
  input  wire logic [9:0] nb,
  input  wire logic [7:0] base,
  output      logic       line_start,
  output      logic [9:0] line_bytes,
  output      logic       byte_valid,
  output      logic [7:0] byte_data,
  output      logic       busy
);
  logic [9:0] cnt;

  // byte lane toggles while idle so a stale byte never looks valid
  always_ff @(posedge core_clk) begin
    line_start <= 1'b0;
    byte_valid <= 1'b0;
    byte_data  <= ~byte_data;
    if (!rst_n) begin
      busy       <= 1'b0;
      cnt        <= 10'h000;
      line_bytes <= 10'h000;
      byte_data  <= 8'h00;
    end else if (go && !busy) begin
      line_start <= 1'b1;
      line_bytes <= nb;
      cnt        <= 10'h000;
      busy       <= 1'b1;
    end else if (busy && cnt == line_bytes) begin
      busy <= 1'b0;
    end else if (busy) begin
      byte_valid <= 1'b1;
      byte_data  <= base + cnt[7:0];
      cnt        <= cnt + 10'h001;
    end
  end
endmodule

// [test/vfs_top_checker.sv]
/*
  vfs_top_checker: port-level properties of vfs_top.
  assumes: bound to vfs_top; mirrors the host writes it needs.
*/
`timescale 1ns/1ps
module vfs_top_checker (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       sync_fall,
  input wire logic [7:0] slice_mode,
  input wire logic       slice_enable,
  input wire logic       settings_load,
  input wire logic       anc_valid,
  input wire logic [7:0] anc_data,
  input wire logic       anc_ready,
  input wire logic       read_regs_clear,
  input wire logic       irq_active
);
  logic [9:0] sw_val;
  logic [9:0] pix;
  logic       seen;
  logic [1:0] ien;
  logic       route;
  wire        flush_wr = reg_wr && reg_addr == 8'hC9;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // shadow of switch pixel, enables, route and the pixel counter
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sw_val <= 10'h04E;
      ien    <= 2'h0;
      route  <= 1'b1;
      seen   <= 1'b0;
      pix    <= 10'h000;
    end else begin
      if (reg_wr && reg_addr == 8'hCB) sw_val[7:0] <= reg_wdata;
      if (reg_wr && reg_addr == 8'hCC) sw_val[9:8] <= reg_wdata[1:0];
      if (reg_wr && reg_addr == 8'hC1) ien <= reg_wdata[2:1];
      if (reg_wr && reg_addr == 8'hCD) route <= reg_wdata[0];
      if (sync_fall) seen <= 1'b1;
      if (sync_fall) pix <= 10'h000;
      else if (pix != 10'h3FF) pix <= pix + 10'h001;
    end
  end

  AST_FLUSH_PULSE: assert property (flush_wr |=> read_regs_clear)
    else $error("no clear pulse after flush write");
  AST_FLUSH_ONLY: assert property (read_regs_clear |-> $past(flush_wr))
    else $error("clear pulse without flush write");
  AST_SLICE_EN: assert property (slice_enable == (slice_mode[3:0] != 4'hF))
    else $error("slice enable disagrees with mode");
  AST_LOAD_PULSE: assert property (settings_load |=> !settings_load)
    else $error("settings load longer than one cycle");
  AST_SWITCH_AT: assert property (seen && pix == sw_val |=> settings_load)
    else $error("settings load missed switch pixel");
  AST_MODE_HOLD: assert property (!settings_load |-> $stable(slice_mode))
    else $error("slice mode moved without load");
  AST_IRQ_MASK: assert property (ien == 2'h0 && $past(ien) == 2'h0 |-> !irq_active)
    else $error("interrupt with all sources masked");
  AST_ANC_HOLD: assert property (anc_valid && !anc_ready && !flush_wr |=> anc_valid && $stable(anc_data))
    else $error("ancillary byte dropped while stalled");
  AST_ANC_ROUTE: assert property (route && $past(route) && $past(route, 2) |-> !anc_valid)
    else $error("ancillary output while routed to host");
endmodule
